/* pkg/rcbp_pkg.sv */
// Shared constants, masks and helpers for the registered command buffer with parity
package rcbp_pkg;

  // Widths
  localparam int unsigned DATA_W = 28;
  localparam int unsigned LANE_W = 2;
  localparam int unsigned HOLD_W = 2;

  // Active data lanes per configuration, bit 0 is lane 1
  localparam logic [DATA_W-1:0] MASK_CFG0 = 28'hfff0f5f;
  localparam logic [DATA_W-1:0] MASK_CFG1 = 28'hfaf0fff;

  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 28'h0000000;
  localparam logic [LANE_W-1:0] LANE_RST = 2'h0;
  localparam logic BIT_RST = 1'b0;
  localparam logic ERR_N_RST = 1'b1;

  // Extra cycles an error stays latched after it is flagged
  localparam logic [HOLD_W-1:0] HOLD_SINGLE = 2'h1;
  // Extra cycles an error stays latched after the low-power state ends
  localparam logic [HOLD_W-1:0] HOLD_AFTER_LP = 2'h2;
  localparam logic [HOLD_W-1:0] HOLD_NONE = 2'h0;

  // Controller-side settle times around reset, and their cycle counts
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned T_ACT_NS = 10;
  localparam int unsigned T_INACT_NS = 15;
  localparam int unsigned T_ACT_CYC = (T_ACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned T_INACT_CYC = (T_INACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Lanes that are buffered and checked for a configuration
  function automatic logic [DATA_W-1:0] rcbp_active_mask(input logic cfg);
    rcbp_active_mask = cfg ? MASK_CFG1 : MASK_CFG0;
  endfunction

  // Even parity fold of the active lanes
  function automatic logic rcbp_fold(input logic [DATA_W-1:0] word, input logic cfg);
    rcbp_fold = ^(word & rcbp_active_mask(cfg));
  endfunction

endpackage

/* pkg/rcbp_err_if.sv */
// Carrier between the buffer datapath and the error latch
`timescale 1ns/10ps
`default_nettype none
interface rcbp_err_if;
  logic chk;
  logic mismatch;
  logic low_power;
  logic err_n;

  modport path (output chk, output mismatch, output low_power, input err_n);
  modport latch (input chk, input mismatch, input low_power, output err_n);
endinterface
`default_nettype wire

/* rtl/rcbp_err_latch.sv */
// Error output latch with minimum hold and low-power extension
`timescale 1ns/10ps
`default_nettype none
module rcbp_err_latch
  import rcbp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  rcbp_err_if.latch err_if
);

  logic err_low_r;
  logic err_low_nxt;
  logic [HOLD_W-1:0] hold_r;
  logic [HOLD_W-1:0] hold_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    err_low_nxt = err_low_r;
    hold_nxt = hold_r;
    if (err_if.chk && err_if.mismatch) begin
      // New error, restart the hold
      err_low_nxt = 1'b1;
      hold_nxt = HOLD_SINGLE;
    end else if (err_low_r && err_if.low_power) begin
      // Low power reloads the hold even on a good word
      hold_nxt = HOLD_AFTER_LP;
    end else if (err_if.chk) begin
      // Good word: release only after the hold ran out
      if (err_low_r && hold_r != HOLD_NONE) begin
        hold_nxt = hold_r - 2'h1;
      end else begin
        err_low_nxt = 1'b0;
      end
    end else if (err_low_r) begin
      // No evaluation, count the hold down only
      if (hold_r != HOLD_NONE) begin
        hold_nxt = hold_r - 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err_low_r <= BIT_RST;
      hold_r <= HOLD_NONE;
    end else begin
      err_low_r <= err_low_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Active low error, high in reset
  assign err_if.err_n = ~err_low_r;

endmodule
`default_nettype wire

/* rtl/rcbp_top.sv */
// Registered command buffer with chip-select gating and parity check
//
// Behaviour
// - Config 0 buffers and checks lanes 1-5, 7, 9-12, 17-28.
// - Config 1 buffers and checks lanes 1-12, 17-20, 22, 24-28.
// - Active outputs follow the same lane sets; inactive outputs stay low.
// - With a chip select low, even ones plus parity keep error high.
// - A single error holds the error output low at least two cycles.
// - Consecutive errors keep the error output low while they persist.
// - Gate enable has no effect on the parity result.
// - Both chip selects and gate enable high enter low power.
// - Error before low power stays low through it plus three cycles.
// - In low power the data outputs hold their previous values.
// - Chip selects, termination and clock enables are always captured.
// - Reset clears registers, outputs low, error output high.
// - Error output is valid two cycles after its word is registered.
`timescale 1ns/10ps
`default_nettype none
module rcbp_top
  import rcbp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic config_sel_i,
  input wire logic cs_gate_enable_i,
  input wire logic chip_select_in_0_i,
  input wire logic chip_select_in_1_i,
  input wire logic [DATA_W-1:0] buffered_inputs_i,
  input wire logic [LANE_W-1:0] term_ctl_in_i,
  input wire logic [LANE_W-1:0] clk_en_in_i,
  input wire logic parity_bit_in_i,
  output logic [DATA_W-1:0] buffered_outputs_o,
  output logic chip_select_out_0_o,
  output logic chip_select_out_1_o,
  output logic [LANE_W-1:0] term_ctl_out_o,
  output logic [LANE_W-1:0] clk_en_out_o,
  output logic parity_error_out_o,
  output logic low_power_state_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Output stage
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] data_nxt;
  logic cs0_r;
  logic cs0_nxt;
  logic cs1_r;
  logic cs1_nxt;
  logic [LANE_W-1:0] odt_r;
  logic [LANE_W-1:0] odt_nxt;
  logic [LANE_W-1:0] cke_r;
  logic [LANE_W-1:0] cke_nxt;
  logic lp_r;
  logic lp_nxt;

  // Parity stage one: the word waiting for its parity bit
  logic [DATA_W-1:0] pword_r;
  logic [DATA_W-1:0] pword_nxt;
  logic pcfg_r;
  logic pcfg_nxt;
  logic pchk_r;
  logic pchk_nxt;

  // Parity stage two: the evaluated result
  logic chk_r;
  logic chk_nxt;
  logic mis_r;
  logic mis_nxt;

  // Decoded inputs
  logic cs_any_low;
  logic lp_enter;
  logic [DATA_W-1:0] mask_now;

  rcbp_err_if err_if ();

  //////////////////////////////////////////////////////////////////////////////
  // Input decode

  assign cs_any_low = ~chip_select_in_0_i | ~chip_select_in_1_i;
  // Low power needs both selects and the gate enable high
  assign lp_enter = chip_select_in_0_i & chip_select_in_1_i & cs_gate_enable_i;
  // Lane set by configuration
  assign mask_now = rcbp_active_mask(config_sel_i);

  //////////////////////////////////////////////////////////////////////////////
  // Output stage next state

  always_comb begin
    data_nxt = data_r;
    if (!lp_enter) begin
      // Copy active lanes, inactive lanes low
      data_nxt = buffered_inputs_i & mask_now;
    end
    // Frozen otherwise
  end

  always_comb begin
    // Never gated by chip selects
    cs0_nxt = chip_select_in_0_i;
    cs1_nxt = chip_select_in_1_i;
    odt_nxt = term_ctl_in_i;
    cke_nxt = clk_en_in_i;
    lp_nxt = lp_enter;
  end

  // Registers update only on the crossing
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_r <= DATA_RST;
      cs0_r <= BIT_RST;
      cs1_r <= BIT_RST;
      odt_r <= LANE_RST;
      cke_r <= LANE_RST;
      lp_r <= BIT_RST;
    end else begin
      data_r <= data_nxt;
      cs0_r <= cs0_nxt;
      cs1_r <= cs1_nxt;
      odt_r <= odt_nxt;
      cke_r <= cke_nxt;
      lp_r <= lp_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parity pipeline next state

  always_comb begin
    // Capture every word with its config and selects; gate enable unused
    pword_nxt = buffered_inputs_i;
    pcfg_nxt = config_sel_i;
    pchk_nxt = cs_any_low;
  end

  always_comb begin
    // Pair the stored word with the parity bit of this cycle
    chk_nxt = pchk_r;
    // Even total is good, odd is an error
    mis_nxt = rcbp_fold(pword_r, pcfg_r) ^ parity_bit_in_i;
  end

  // Word at edge n, result at n+1, error output at n+2
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pword_r <= DATA_RST;
      pcfg_r <= BIT_RST;
      pchk_r <= BIT_RST;
      chk_r <= BIT_RST;
      mis_r <= BIT_RST;
    end else begin
      pword_r <= pword_nxt;
      pcfg_r <= pcfg_nxt;
      pchk_r <= pchk_nxt;
      chk_r <= chk_nxt;
      mis_r <= mis_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Error latch

  // No check when both selects were high
  assign err_if.chk = chk_r;
  assign err_if.mismatch = mis_r;
  // Low-power extension of a latched error
  assign err_if.low_power = lp_r;

  rcbp_err_latch u_err_latch (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .err_if (err_if.latch)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign buffered_outputs_o = data_r;
  assign chip_select_out_0_o = cs0_r;
  assign chip_select_out_1_o = cs1_r;
  assign term_ctl_out_o = odt_r;
  assign clk_en_out_o = cke_r;
  assign low_power_state_o = lp_r;
  assign parity_error_out_o = err_if.err_n;

endmodule
`default_nettype wire

/* dv/rcbp_ctl_model.sv */
// Controller model that sends parity one cycle after its word
`timescale 1ns/10ps
`default_nettype none
module rcbp_ctl_model
  import rcbp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic config_sel_i,
  input wire logic [DATA_W-1:0] word_i,
  input wire logic flip_i,
  output logic parity_bit_o
);
  // Even parity of the word just taken, corrupted on request
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      parity_bit_o <= 1'b0;
    end else begin
      parity_bit_o <= #1 flip_i ^ (^(word_i & (config_sel_i ? MASK_CFG1 : MASK_CFG0)));
    end
  end
endmodule
`default_nettype wire

/* dv/rcbp_properties.sv */
// Port checker for the command buffer
`timescale 1ns/10ps
`default_nettype none
module rcbp_properties
  import rcbp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic config_sel_i,
  input wire logic cs_gate_enable_i,
  input wire logic chip_select_in_0_i,
  input wire logic chip_select_in_1_i,
  input wire logic [DATA_W-1:0] buffered_inputs_i,
  input wire logic [LANE_W-1:0] term_ctl_in_i,
  input wire logic [LANE_W-1:0] clk_en_in_i,
  input wire logic parity_bit_in_i,
  input wire logic [DATA_W-1:0] buffered_outputs_o,
  input wire logic chip_select_out_0_o,
  input wire logic chip_select_out_1_o,
  input wire logic [LANE_W-1:0] term_ctl_out_o,
  input wire logic [LANE_W-1:0] clk_en_out_o,
  input wire logic parity_error_out_o,
  input wire logic low_power_state_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic cs_any;
  logic lp_in;
  logic [DATA_W-1:0] mask;
  assign cs_any = !chip_select_in_0_i || !chip_select_in_1_i;
  assign lp_in = !cs_any && cs_gate_enable_i;
  assign mask = config_sel_i ? MASK_CFG1 : MASK_CFG0;
  sequence s_bad;
    cs_any ##1 (parity_bit_in_i ^ (^($past(buffered_inputs_i) & $past(mask))));
  endsequence
  property p_copy;
    !lp_in |=> buffered_outputs_o == $past(buffered_inputs_i & mask);
  endproperty
  property p_freeze;
    lp_in |=> $stable(buffered_outputs_o);
  endproperty
  property p_lp;
    1'b1 |=> low_power_state_o == $past(lp_in);
  endproperty
  property p_ctl;
    1'b1 |=> {term_ctl_out_o, clk_en_out_o, chip_select_out_0_o, chip_select_out_1_o} ==
      $past({term_ctl_in_i, clk_en_in_i, chip_select_in_0_i, chip_select_in_1_i});
  endproperty
  property p_set;
    s_bad |=> ##1 !parity_error_out_o;
  endproperty
  property p_min;
    $fell(parity_error_out_o) |=> !parity_error_out_o;
  endproperty
  property p_skip;
    !cs_any ##2 parity_error_out_o |=> parity_error_out_o;
  endproperty
  property p_lpext;
    !parity_error_out_o && low_power_state_o |=> !parity_error_out_o [*2];
  endproperty
  a_copy: assert property (p_copy) else $error("data copy wrong");
  a_freeze: assert property (p_freeze) else $error("data not held");
  a_lp: assert property (p_lp) else $error("low power flag wrong");
  a_ctl: assert property (p_ctl) else $error("control copy wrong");
  a_set: assert property (p_set) else $error("error not flagged");
  a_min: assert property (p_min) else $error("error too short");
  a_skip: assert property (p_skip) else $error("error set unselected");
  a_lpext: assert property (p_lpext) else $error("low power hold short");
endmodule
bind rcbp_top rcbp_properties rcbp_properties_inst (.*);
`default_nettype wire

/* dv/rcbp_top_tb.sv */
// Self-checking bench for the command buffer
`timescale 1ns/10ps
`default_nettype none
module rcbp_top_tb
  import rcbp_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cfg = 1'b0, gate = 1'b0, cs0 = 1'b1, cs1 = 1'b1, flip = 1'b0;
  logic par, cso0, cso1, err, lp;
  logic [DATA_W-1:0] din = '0, dout, held, w;
  logic [LANE_W-1:0] tco, ceo;
  int fail_count = 0;
  int checked = 0;
  rcbp_top rcbp_top_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .config_sel_i(cfg),
    .cs_gate_enable_i(gate), .chip_select_in_0_i(cs0), .chip_select_in_1_i(cs1),
    .buffered_inputs_i(din), .term_ctl_in_i(din[1:0]), .clk_en_in_i(din[3:2]),
    .parity_bit_in_i(par), .buffered_outputs_o(dout), .chip_select_out_0_o(cso0),
    .chip_select_out_1_o(cso1), .term_ctl_out_o(tco), .clk_en_out_o(ceo),
    .parity_error_out_o(err), .low_power_state_o(lp));
  rcbp_ctl_model rcbp_ctl_model_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .config_sel_i(cfg), .word_i(din), .flip_i(flip), .parity_bit_o(par));
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic drv(input logic c, input logic g, input logic s0, input logic s1,
    input logic [DATA_W-1:0] d, input logic f);
    cfg = c;
    gate = g;
    cs0 = s0;
    cs1 = s1;
    din = d;
    flip = f;
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    chk({dout, err}, {DATA_RST, ERR_N_RST});
    #1;
    reset_n_i = 1'b1;
    repeat (T_ACT_CYC) drv(0, 0, 1, 1, '0, 0);
    for (int i = 0; i < 8; i++) begin
      w = {7{i[3:0]}} ^ 28'h5a96c3e;
      drv(i[0], 0, i[1], i[2], w, 0);
      chk(dout, w & (i[0] ? MASK_CFG1 : MASK_CFG0));
      chk({tco, ceo, cso0, cso1}, {w[1:0], w[3:2], cs0, cs1});
    end
    held = dout;
    drv(1, 1, 1, 1, ~w, 0);
    chk({dout, lp, ceo}, {held, 1'b1, ~w[3:2]});
    drv(0, 1, 0, 1, w, 0);
    chk(dout, w & MASK_CFG0);
    chk(err, 1'b1);
    drv(0, 1, 0, 1, w, 1);
    drv(0, 0, 0, 0, w, 0);
    chk(err, 1'b1);
    drv(0, 0, 0, 0, w, 0);
    chk(err, 1'b0);
    drv(0, 0, 0, 0, w, 0);
    chk(err, 1'b0);
    repeat (4) drv(0, 0, 0, 0, w, 0);
    chk(err, 1'b1);
    drv(0, 0, 0, 0, w, 1);
    repeat (3) drv(0, 1, 1, 1, w, 0);
    drv(0, 0, 0, 0, w, 0);
    chk(err, 1'b0);
    drv(0, 0, 0, 0, w, 0);
    chk(err, 1'b0);
    repeat (6) drv(0, 0, 0, 0, w, 0);
    for (int k = 0; k < 5; k++) begin
      drv(1, 0, 1, 0, w, k < 3);
    end
    chk(err, 1'b0);
    drv(1, 0, 1, 0, w, 0);
    chk(err, 1'b0);
    reset_n_i = 1'b0;
    #1;
    chk({dout, err, lp}, {DATA_RST, ERR_N_RST, 1'b0});
    give_verdict();
  end
endmodule
`default_nettype wire
